// ---- rtl/crog_pkg.sv ----
/*
  types of the clock request gating block.
  assumes: crog_regs.svh is on the include path.
*/
package crog_pkg;
  `include "crog_regs.svh"

  localparam int CROG_PAIRS = 6;

  // one set of leg levels and enables for all peripheral pairs
  typedef struct packed {
    logic [CROG_PAIRS-1:0] true_leg;
    logic [CROG_PAIRS-1:0] true_oe;
    logic [CROG_PAIRS-1:0] comp_leg;
    logic [CROG_PAIRS-1:0] comp_oe;
  } crog_pairs_t;

  // byte-wide register access from the serial bus engine
  typedef struct packed {
    logic wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
  } crog_reg_req_t;

  typedef enum logic [1:0] {
    CROG_OUT_NORMAL = 2'b00,
    CROG_OUT_TRISTATE = 2'b01,
    CROG_OUT_REFDIV = 2'b10
  } crog_out_mode_t;
endpackage

// ---- rtl/crog_regs.svh ----
/*
  offsets, field positions, reset values and counts of the clock request gating block.
  assumes: included by the package and by the top module, by bare name.
*/
`ifndef CROG_REGS_SVH
`define CROG_REGS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CROG_OFS_STOP_DRIVE 8'h03
`define CROG_OFS_REQ0_SEL 8'h04
`define CROG_OFS_REQ1_SEL 8'h05
`define CROG_OFS_TEST_DRIVE 8'h06
`define CROG_OFS_ID 8'h07

// ----------------------------------------
// field positions
// ----------------------------------------
`define CROG_SEL_MSB 7
`define CROG_SEL_LSB 2
`define CROG_LINK_EN_BIT 1
`define CROG_STOP_MODE_BIT 7
`define CROG_TEST_SEL_BIT 7
`define CROG_TEST_MODE_BIT 6
`define CROG_REF_DRIVE_BIT 5
`define CROG_RSVD_ONE_BIT 4

// ----------------------------------------
// reset values
// ----------------------------------------
`define CROG_RST_SEL 6'h00
`define CROG_RST_LINK_EN 1'b1
`define CROG_RST_REQ0_RSVD 1'b1
`define CROG_RST_STOP_MODE 1'b1
`define CROG_RST_TEST_SEL 1'b0
`define CROG_RST_TEST_MODE 1'b0
`define CROG_RST_REF_DRIVE 1'b0

// ----------------------------------------
// counts
// ----------------------------------------
`define CROG_REF_DIV_CYCLES 4

`endif

// ---- rtl/crog_top.sv ----
/*
  clock request gating: stops and restarts peripheral differential pairs on two
  active-low asynchronous request inputs, with the control bytes that steer it.
  assumes: the serial bus engine outside presents one byte access per cycle on
  reg_req; request pins and the strap pins are asynchronous to clk.
*/
`timescale 1ns/1ps
`include "crog_regs.svh"

module crog_top #(
  parameter int REF_DIV = `CROG_REF_DIV_CYCLES,
  parameter logic [7:0] ID_VALUE = 8'h5a // arbitrary value
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire crog_pkg::crog_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic clock_request_n_0,
  input wire logic clock_request_n_1,
  input wire logic [3:0] hw_strap,
  output crog_pkg::crog_pairs_t periph_diff_clock_pair,
  output logic diff_complement_output,
  output logic link_66mhz_clock,
  output logic ref_drive_high
);
  import crog_pkg::*;

  // ----------------------------------------
  // control bytes
  // ----------------------------------------
  logic [5:0] sel0_q;
  logic [5:0] sel1_q;
  logic link_en_q;
  logic stop_mode_q;
  logic test_sel_q;
  logic test_mode_q;
  logic ref_drive_q;
  logic [3:0] strap_meta_q;
  logic [3:0] strap_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sel0_q <= `CROG_RST_SEL;
      sel1_q <= `CROG_RST_SEL;
      link_en_q <= `CROG_RST_LINK_EN;
      stop_mode_q <= `CROG_RST_STOP_MODE;
      test_sel_q <= `CROG_RST_TEST_SEL;
      test_mode_q <= `CROG_RST_TEST_MODE;
      ref_drive_q <= `CROG_RST_REF_DRIVE;
    end else if (reg_req.wr_en) begin
      case (reg_req.addr)
        `CROG_OFS_STOP_DRIVE: stop_mode_q <= reg_req.wdata[`CROG_STOP_MODE_BIT];
        `CROG_OFS_REQ0_SEL: begin
          sel0_q <= reg_req.wdata[`CROG_SEL_MSB:`CROG_SEL_LSB];
          link_en_q <= reg_req.wdata[`CROG_LINK_EN_BIT];
        end
        `CROG_OFS_REQ1_SEL: sel1_q <= reg_req.wdata[`CROG_SEL_MSB:`CROG_SEL_LSB];
        `CROG_OFS_TEST_DRIVE: begin
          test_sel_q <= reg_req.wdata[`CROG_TEST_SEL_BIT];
          test_mode_q <= reg_req.wdata[`CROG_TEST_MODE_BIT];
          ref_drive_q <= reg_req.wdata[`CROG_REF_DRIVE_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // straps are pins, so they are synchronised before the readback sees them
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      strap_meta_q <= 4'h0;
      strap_q <= 4'h0;
    end else begin
      strap_meta_q <= hw_strap;
      strap_q <= strap_meta_q;
    end
  end

  // ----------------------------------------
  // readback
  // ----------------------------------------
  logic [7:0] rdata_d;

  always_comb begin
    rdata_d = 8'h00;
    case (reg_req.addr)
      `CROG_OFS_STOP_DRIVE: rdata_d[`CROG_STOP_MODE_BIT] = stop_mode_q;
      `CROG_OFS_REQ0_SEL: rdata_d = {sel0_q, link_en_q, `CROG_RST_REQ0_RSVD};
      `CROG_OFS_REQ1_SEL: rdata_d = {sel1_q, 2'b00};
      `CROG_OFS_TEST_DRIVE: rdata_d = {test_sel_q, test_mode_q, ref_drive_q, 1'b1, strap_q};
      `CROG_OFS_ID: rdata_d = ID_VALUE;
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= rdata_d;
    end
  end

  // ----------------------------------------
  // output phase and divided reference
  // ----------------------------------------
  logic phase_q;
  logic ref_div_q;
  logic [7:0] ref_cnt_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      phase_q <= 1'b0;
    end else begin
      phase_q <= ~phase_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ref_cnt_q <= 8'h00;
      ref_div_q <= 1'b0;
    end else if (ref_cnt_q == 8'(REF_DIV - 1)) begin
      ref_cnt_q <= 8'h00;
      ref_div_q <= ~ref_div_q;
    end else begin
      ref_cnt_q <= ref_cnt_q + 8'h01;
    end
  end

  // ----------------------------------------
  // request synchronise and debounce
  // ----------------------------------------
  logic [1:0] req_meta_q;
  logic [1:0] req_sync_q;
  logic [1:0] req_smp_q;
  logic [1:0] req_lvl_q; // 1 = deasserted, pairs stop
  logic comp_edge;

  // the complement leg rises on the edge where the phase leaves 1
  assign comp_edge = phase_q;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_meta_q <= 2'b00;
      req_sync_q <= 2'b00;
    end else begin
      req_meta_q <= {clock_request_n_1, clock_request_n_0};
      req_sync_q <= req_meta_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      req_smp_q <= 2'b00;
      req_lvl_q <= 2'b00;
    end else if (comp_edge) begin
      req_smp_q <= req_sync_q;
      // a level counts only once two consecutive samples agree
      for (int r = 0; r < 2; r++) begin
        if (req_smp_q[r] == req_sync_q[r]) begin
          req_lvl_q[r] <= req_sync_q[r];
        end
      end
    end
  end

  // ----------------------------------------
  // gating per pair
  // ----------------------------------------
  logic [5:0] stop_req;
  logic [5:0] running_q;
  crog_out_mode_t out_mode;

  assign stop_req = (sel0_q & {6{req_lvl_q[0]}}) | (sel1_q & {6{req_lvl_q[1]}});

  // updates only while true is high, so a stopped pair is frozen high
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      running_q <= 6'h3f;
    end else if (phase_q) begin
      running_q <= ~stop_req;
    end
  end

  always_comb begin
    if (!test_mode_q) begin
      out_mode = CROG_OUT_NORMAL;
    end else if (test_sel_q) begin
      out_mode = CROG_OUT_REFDIV;
    end else begin
      out_mode = CROG_OUT_TRISTATE;
    end
  end

  for (genvar i = 0; i < CROG_PAIRS; i++) begin : g_pair
    always_ff @(posedge clk) begin
      if (!rst_n) begin
        periph_diff_clock_pair.true_leg[i] <= 1'b0;
        periph_diff_clock_pair.comp_leg[i] <= 1'b1;
        periph_diff_clock_pair.true_oe[i] <= 1'b1;
        periph_diff_clock_pair.comp_oe[i] <= 1'b1;
      end else begin
        case (out_mode)
          CROG_OUT_REFDIV: begin
            periph_diff_clock_pair.true_leg[i] <= ref_div_q;
            periph_diff_clock_pair.comp_leg[i] <= ~ref_div_q;
            periph_diff_clock_pair.true_oe[i] <= 1'b1;
            periph_diff_clock_pair.comp_oe[i] <= 1'b1;
          end
          CROG_OUT_TRISTATE: begin
            periph_diff_clock_pair.true_leg[i] <= 1'b0;
            periph_diff_clock_pair.comp_leg[i] <= 1'b0;
            periph_diff_clock_pair.true_oe[i] <= 1'b0;
            periph_diff_clock_pair.comp_oe[i] <= 1'b0;
          end
          default: begin
            // stopped: legs hold the levels they take for phase 0, true high and complement low
            periph_diff_clock_pair.true_leg[i] <= running_q[i] ? ~phase_q : 1'b1;
            periph_diff_clock_pair.comp_leg[i] <= running_q[i] ? phase_q : 1'b0;
            periph_diff_clock_pair.true_oe[i] <= running_q[i] | ~stop_mode_q;
            periph_diff_clock_pair.comp_oe[i] <= running_q[i] | ~stop_mode_q;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      diff_complement_output <= 1'b1;
      link_66mhz_clock <= 1'b0;
      ref_drive_high <= 1'b0;
    end else begin
      diff_complement_output <= phase_q;
      link_66mhz_clock <= link_en_q & ~phase_q;
      ref_drive_high <= ref_drive_q;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  a_sel0_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr == `CROG_OFS_REQ0_SEL |=> sel0_q == $past(reg_req.wdata[7:2]))
    else $error("request 0 select not stored");
  a_sel1_write: assert property (@(posedge clk) disable iff (!rst_n)
    reg_req.wr_en && reg_req.addr == `CROG_OFS_REQ1_SEL |=> sel1_q == $past(reg_req.wdata[7:2]))
    else $error("request 1 select not stored");
  a_link_gated: assert property (@(posedge clk) disable iff (!rst_n)
    !link_en_q |=> !link_66mhz_clock)
    else $error("link clock runs while disabled");
  a_test_tristate: assert property (@(posedge clk) disable iff (!rst_n)
    test_mode_q && !test_sel_q |=> periph_diff_clock_pair.true_oe == 6'h00)
    else $error("test three-state not applied");
  a_free_running: assert property (@(posedge clk) disable iff (!rst_n)
    (sel0_q | sel1_q) == 6'h00 [*3] |-> running_q == 6'h3f)
    else $error("unselected pair stopped");
  a_debounce_two: assert property (@(posedge clk) disable iff (!rst_n)
    req_lvl_q[0] != $past(req_lvl_q[0]) |-> $past(req_smp_q[0]) == req_lvl_q[0])
    else $error("request accepted on one sample");
  a_stop_park: assert property (@(posedge clk) disable iff (!rst_n)
    !test_mode_q && !stop_mode_q && running_q != 6'h3f |=>
      ((periph_diff_clock_pair.true_leg & ~periph_diff_clock_pair.comp_leg
      & periph_diff_clock_pair.true_oe & periph_diff_clock_pair.comp_oe)
      | $past(running_q)) == 6'h3f)
    else $error("stopped pair not parked high");
  a_stop_float: assert property (@(posedge clk) disable iff (!rst_n)
    !test_mode_q && stop_mode_q && running_q != 6'h3f |=>
      ((periph_diff_clock_pair.true_oe | periph_diff_clock_pair.comp_oe)
      & ~$past(running_q)) == 6'h00)
    else $error("stopped pair still driven");
  a_phase_boundary: assert property (@(posedge clk) disable iff (!rst_n)
    running_q != $past(running_q) |-> $past(phase_q))
    else $error("gating changed mid phase");
  a_restart_bound: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(req_lvl_q[0]) && !req_lvl_q[1] |-> ##[1:2] (running_q & sel0_q) == sel0_q)
    else $error("restart too late");
endmodule // crog_top

// ---- test/crog_req_model.sv ----
/*
  peripheral side model: drives the two active-low clock request pins.
  assumes: the bench raises want_0 / want_1 while that peripheral needs its clock.
*/
`timescale 1ns/1ps

module crog_req_model #(
  parameter realtime SKEW = 7.3
) (
  input wire logic want_0,
  input wire logic want_1,
  output wire logic clock_request_n_0,
  output wire logic clock_request_n_1
);
  // ----------------------------------------
  // pin drive
  // ----------------------------------------
  // odd skew keeps pin edges off the clock grid, so the pins stay truly asynchronous
  assign #SKEW clock_request_n_0 = ~want_0;
  assign #SKEW clock_request_n_1 = ~want_1;
endmodule // crog_req_model

// ---- test/test_crog_top.sv ----
/*
  self-checking bench of the clock request gating block.
  assumes: crog_pkg, crog_top and crog_req_model are compiled before it.
*/
`timescale 1ns/1ps

module test_crog_top;
  import crog_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  crog_reg_req_t reg_req = '0;
  logic [7:0] reg_rdata;
  logic want_0 = 1'b1;
  logic want_1 = 1'b1;
  wire logic req_n_0;
  wire logic req_n_1;
  crog_pairs_t pairs;
  logic dco;
  logic link;
  logic ref_hi;
  int miscompares = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;

  // id value arbitrary; short divider keeps the run brief
  crog_top #(.REF_DIV(2), .ID_VALUE(8'h3c)) i_crog_top (.clk(clk), .rst_n(rst_n),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .clock_request_n_0(req_n_0),
    .clock_request_n_1(req_n_1), .hw_strap(4'ha), .periph_diff_clock_pair(pairs),
    .diff_complement_output(dco), .link_66mhz_clock(link), .ref_drive_high(ref_hi));
  crog_req_model i_crog_req_model (.want_0(want_0), .want_1(want_1),
    .clock_request_n_0(req_n_0), .clock_request_n_1(req_n_1));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_req = '{wr_en: 1'b1, addr: a, wdata: d};
    @(negedge clk);
    reg_req.wr_en = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd(input string what, input logic [7:0] a, input logic [7:0] exp);
    reg_req.addr = a;
    @(negedge clk);
    check(what, exp, reg_rdata);
  endtask

  task automatic wrap_up;
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // one stop and restart on request idx; fr is a pair left free running
  task automatic gate_cycle(input bit idx, input logic [5:0] m, input bit off, input int fr);
    int n;
    logic done;
    logic prev;
    logic was_parked;
    n = 0;
    done = 1'b0;
    was_parked = 1'b0;
    if (idx) want_1 = 1'b0; else want_0 = 1'b0;
    // running pairs show true high half the time, so parked must hold two samples
    while (!done && n < 14) begin
      @(negedge clk);
      n++;
      done = off ? ((pairs.true_oe | pairs.comp_oe) & m) == 6'h00
                 : was_parked && ((pairs.true_leg & ~pairs.comp_leg & m) == m);
      was_parked = (pairs.true_leg & ~pairs.comp_leg & m) == m;
    end
    check("stop latency", 8'h01, {7'h00, n <= 12});
    prev = pairs.comp_leg[fr];
    repeat (6) begin
      @(negedge clk);
      check("parked true oe", {2'b00, off ? 6'h00 : m}, {2'b00, pairs.true_oe & m});
      check("parked comp oe", {2'b00, off ? 6'h00 : m}, {2'b00, pairs.comp_oe & m});
      if (!off) check("parked legs", {2'b00, m}, {2'b00, pairs.true_leg & ~pairs.comp_leg & m});
      check("free pair runs", 8'h01, {7'h00, pairs.comp_leg[fr] !== prev});
      check("complement output", {7'h00, pairs.comp_leg[fr]}, {7'h00, dco});
      prev = pairs.comp_leg[fr];
    end
    if (idx) want_1 = 1'b1; else want_0 = 1'b1;
    n = 0;
    done = 1'b0;
    while (!done && n < 14) begin
      @(negedge clk);
      n++;
      done = (pairs.comp_leg & pairs.comp_oe & m) == m;
    end
    check("restart latency", 8'h01, {7'h00, n <= 12});
    repeat (6) begin
      @(negedge clk);
      check("restart true", {2'b00, m & {6{pairs.true_leg[fr]}}}, {2'b00, pairs.true_leg & m});
      check("restart comp", {2'b00, m & {6{pairs.comp_leg[fr]}}}, {2'b00, pairs.comp_leg & m});
    end
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_values;
    rd("byte3", 8'h03, 8'h80);
    rd("byte4", 8'h04, 8'h03);
    rd("byte5", 8'h05, 8'h00);
    rd("byte6", 8'h06, 8'h1a);
    rd("byte7", 8'h07, 8'h3c);
    rd("unmapped", 8'h08, 8'h00);
    check("drive low", 8'h00, {7'h00, ref_hi});
  endtask

  task automatic t_regs;
    logic a;
    wr(8'h04, 8'hfc);
    rd("byte4 rw", 8'h04, 8'hfd);
    repeat (4) begin
      @(negedge clk);
      check("link off", 8'h00, {7'h00, link});
    end
    wr(8'h04, 8'h02);
    rd("byte4 back", 8'h04, 8'h03);
    a = link;
    @(negedge clk);
    check("link runs", 8'h01, {7'h00, link !== a});
    wr(8'h05, 8'hfc);
    rd("byte5 rw", 8'h05, 8'hfc);
    wr(8'h07, 8'h00);
    rd("byte7 ro", 8'h07, 8'h3c);
    wr(8'h06, 8'h20);
    rd("byte6 rw", 8'h06, 8'h3a);
    check("drive high", 8'h01, {7'h00, ref_hi});
    wr(8'h06, 8'h00);
    wr(8'h05, 8'h00);
  endtask

  task automatic t_stop_driven;
    wr(8'h03, 8'h00);
    wr(8'h04, 8'haa);
    gate_cycle(1'b0, 6'b101010, 1'b0, 0);
  endtask

  task automatic t_stop_released;
    wr(8'h03, 8'h80);
    wr(8'h04, 8'h02);
    wr(8'h05, 8'h54);
    gate_cycle(1'b1, 6'b010101, 1'b1, 1);
  endtask

  task automatic t_glitch;
    want_1 = 1'b0;
    @(negedge clk);
    want_1 = 1'b1;
    repeat (12) begin
      @(negedge clk);
      check("short pulse", 8'h15, {2'b00, pairs.comp_oe & 6'h15});
    end
  endtask

  task automatic t_test_mode;
    logic a;
    int k;
    wr(8'h06, 8'h40);
    repeat (4) @(negedge clk);
    check("test tristate", 8'h00, {2'b00, pairs.true_oe | pairs.comp_oe});
    wr(8'h06, 8'hc0);
    repeat (4) @(negedge clk);
    check("test divided", 8'h3f, {2'b00, pairs.true_oe & pairs.comp_oe});
    // divided clock flips every REF_DIV cycles, REF_DIV is 2 here
    a = pairs.true_leg[0];
    k = 0;
    while (pairs.true_leg[0] === a && k < 8) begin
      @(negedge clk);
      k++;
    end
    check("divided toggles", 8'h01, {7'h00, k < 8});
    a = pairs.true_leg[0];
    @(negedge clk);
    check("divided hold", {7'h00, a}, {7'h00, pairs.true_leg[0]});
    @(negedge clk);
    check("divided true", {2'b00, {6{~a}}}, {2'b00, pairs.true_leg});
    check("divided comp", {2'b00, {6{a}}}, {2'b00, pairs.comp_leg});
    wr(8'h06, 8'h00);
    repeat (4) @(negedge clk);
    check("normal oe", 8'h3f, {2'b00, pairs.true_oe & pairs.comp_oe});
  endtask

  initial begin
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    t_reset_values;
    t_regs;
    t_stop_driven;
    t_stop_released;
    t_glitch;
    t_test_mode;
    wrap_up;
  end

  // whole run is well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk);
    miscompares++;
    wrap_up;
  end
endmodule // test_crog_top
